// [fas_fault_snapshot.sv]
// Alert, status, snapshot capture, settings storage and on/off control
module fas_fault_snapshot #(
    parameter int RC_HOLD_CYC = fas_pkg::RC_HOLD_CYC,
    parameter int CAP_DEPTH   = fas_pkg::CAP_DEPTH
) (
    // Clock and reset
    input  wire logic        clk,
    input  wire logic        reset,
    // Bus pins
    input  wire logic        scl_in,
    input  wire logic        sda_in,
    output logic             sda_out,
    output logic             sda_oe,
    output logic             alert_line_out,
    output logic             alert_line_oe,
    // Remote on/off and input voltage
    input  wire logic        remote_onoff_pin,
    input  wire logic [15:0] vin_level,
    input  wire logic [15:0] vin_on_th,
    input  wire logic [15:0] vin_off_th,
    // Fault conditions per class
    input  wire logic [7:0]  fault_vout,
    input  wire logic [7:0]  fault_iout,
    input  wire logic [7:0]  fault_input,
    input  wire logic [7:0]  fault_temp,
    input  wire logic [7:0]  fault_cml,
    input  wire logic        power_good,
    // Telemetry
    input  wire logic [15:0] tele_vout,
    input  wire logic [15:0] tele_iout,
    input  wire logic [15:0] tele_duty,
    input  wire logic [15:0] tele_temp1,
    input  wire logic [15:0] tele_temp2,
    input  wire logic [15:0] op_time,
    // Converter control
    output logic             output_enable,
    output logic [15:0]      vout_target
);
    localparam int CW = $clog2(CAP_DEPTH);
    localparam int NC = fas_pkg::N_CLASS;

    logic        rx_valid;
    logic [7:0]  rx_data;
    logic [7:0]  rx_idx;
    logic [7:0]  tx_idx;
    logic [7:0]  tx_data;
    logic [7:0]  cmd_q;
    logic [7:0]  lo_q;
    logic        clr;
    logic        restore;
    logic        store;
    logic        boot_q;
    logic [1:0]  rc_sy;
    logic        rc_open_q;
    logic [12:0] rc_cnt_q;
    logic        running_q;
    logic        en_d;
    logic        en_rise;
    logic        alert_q;
    logic        evt_any;
    logic        raw_evt;
    logic        snap_wr;
    logic [7:0]  flt     [NC];
    logic [7:0]  stat_q  [NC];
    logic [7:0]  mask_q  [NC];
    logic [7:0]  umask_q [NC];
    logic [NC-1:0] evt_v;
    logic [NC-1:0] raw_v;
    logic [15:0] vout_q;
    logic [15:0] trim_q;
    logic [15:0] uvout_q;
    logic [15:0] utrim_q;
    logic [15:0] old_q   [4];
    logic [15:0] rec     [fas_pkg::REC_WORDS];
    logic [15:0] mem_q   [CAP_DEPTH][fas_pkg::REC_WORDS];
    logic [CW-1:0] wr_ptr_q;
    logic [CW-1:0] sel_q;
    logic [CW-1:0] rd_slot;
    logic [15:0] cycles_q;
    logic [7:0]  sbyte;
    logic [15:0] sword;

    fas_link u_link (
        .clk      (clk),
        .reset    (reset),
        .scl_in   (scl_in),
        .sda_in   (sda_in),
        .sda_out  (sda_out),
        .sda_oe   (sda_oe),
        .rx_valid (rx_valid),
        .rx_data  (rx_data),
        .rx_idx   (rx_idx),
        .tx_idx   (tx_idx),
        .tx_data  (tx_data)
    );

    assign flt[0] = fault_vout;
    assign flt[1] = fault_iout;
    assign flt[2] = fault_input;
    assign flt[3] = fault_temp;
    assign flt[4] = fault_cml;

    // Send-byte commands act on the command byte itself
    assign clr     = rx_valid && rx_idx == 8'h00 && rx_data == fas_pkg::CMD_CLEAR_FAULTS;
    assign restore = rx_valid && rx_idx == 8'h00 && rx_data == fas_pkg::CMD_RESTORE_DEF;
    assign store   = rx_valid && rx_idx == 8'h00 && rx_data == fas_pkg::CMD_STORE_USER;

    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            cmd_q <= 8'h00;
            lo_q  <= 8'h00;
            sel_q <= '0;
        end else if (rx_valid) begin
            if (rx_idx == 8'h00) begin
                cmd_q <= rx_data;
            end else if (rx_idx == 8'h01) begin
                lo_q <= rx_data;
                if (cmd_q == fas_pkg::CMD_CAP_SELECT) begin
                    sel_q <= rx_data[CW-1:0];
                end
            end
        end
    end

    // Remote pin: synchronise, then accept a new level only after it held long enough
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            rc_sy     <= 2'h3;
            rc_open_q <= 1'b1;
            rc_cnt_q  <= 13'h0000;
        end else begin
            rc_sy <= {rc_sy[0], remote_onoff_pin};
            if (rc_sy[1] == rc_open_q) begin
                rc_cnt_q <= 13'h0000;
            end else if (rc_cnt_q == 13'(RC_HOLD_CYC - 1)) begin
                rc_open_q <= rc_sy[1];
                rc_cnt_q  <= 13'h0000;
            end else begin
                rc_cnt_q <= rc_cnt_q + 13'h0001;
            end
        end
    end

    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            running_q <= 1'b0;
        end else if (vin_level >= vin_on_th) begin
            running_q <= 1'b1;
        end else if (vin_level < vin_off_th) begin
            running_q <= 1'b0;
        end
    end

    assign en_d    = running_q & ~rc_open_q;
    assign en_rise = en_d & ~output_enable;

    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            output_enable <= 1'b0;
        end else begin
            output_enable <= en_d;
        end
    end

    // Sticky status per class; a new fault wins over a clear
    for (genvar i = 0; i < NC; i++) begin : g_class
        assign raw_v[i] = |(flt[i] & ~stat_q[i]);
        assign evt_v[i] = |(flt[i] & ~stat_q[i] & ~mask_q[i]);
        always_ff @(posedge clk or posedge reset) begin
            if (reset) begin
                stat_q[i] <= 8'h00;
            end else begin
                stat_q[i] <= (clr ? 8'h00 : stat_q[i]) | flt[i];
            end
        end
    end

    assign evt_any = |evt_v;
    assign raw_evt = |raw_v;

    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            alert_q <= 1'b0;
        end else begin
            alert_q <= evt_any | (alert_q & ~(clr | en_rise));
        end
    end

    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            alert_line_out <= 1'b0;
            alert_line_oe  <= 1'b0;
        end else begin
            alert_line_oe  <= alert_q;
        end
    end

    // Active settings, user area, boot load
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            boot_q  <= 1'b1;
            vout_q  <= fas_pkg::DEF_VOUT;
            trim_q  <= fas_pkg::DEF_TRIM;
            uvout_q <= fas_pkg::DEF_VOUT;
            utrim_q <= fas_pkg::DEF_TRIM;
            for (int i = 0; i < NC; i++) begin
                mask_q[i]  <= fas_pkg::DEF_MASK;
                umask_q[i] <= fas_pkg::DEF_MASK;
            end
        end else begin
            boot_q <= 1'b0;
            if (boot_q) begin
                vout_q <= uvout_q;
                trim_q <= utrim_q;
                mask_q <= umask_q;
            end else if (restore) begin
                vout_q <= fas_pkg::DEF_VOUT;
                trim_q <= fas_pkg::DEF_TRIM;
                for (int i = 0; i < NC; i++) begin
                    mask_q[i] <= fas_pkg::DEF_MASK;
                end
            end else if (store) begin
                uvout_q <= vout_q;
                utrim_q <= trim_q;
                umask_q <= mask_q;
            end else if (rx_valid && rx_idx == 8'h02) begin
                if (cmd_q == fas_pkg::CMD_VOUT_SET) begin
                    vout_q <= {rx_data, lo_q};
                end else if (cmd_q == fas_pkg::CMD_VOUT_TRIM) begin
                    trim_q <= {rx_data, lo_q};
                end else if (cmd_q == fas_pkg::CMD_ALERT_MASK &&
                             lo_q >= fas_pkg::CMD_STAT_FIRST &&
                             lo_q < fas_pkg::CMD_STAT_FIRST + 8'(NC)) begin
                    mask_q[3'(lo_q - fas_pkg::CMD_STAT_FIRST)] <= rx_data;
                end
            end
        end
    end

    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            vout_target <= fas_pkg::DEF_VOUT + fas_pkg::DEF_TRIM;
        end else begin
            vout_target <= vout_q + trim_q;
        end
    end

    // Summary status
    always_comb begin
        sbyte = 8'h00;
        sword = 16'h0000;
        sbyte[fas_pkg::SB_OFF]   = ~output_enable;
        sbyte[fas_pkg::SB_CML]   = |stat_q[4];
        sbyte[fas_pkg::SB_OTHER] = |stat_q[3];
        sword[7:0]               = sbyte;
        sword[fas_pkg::SW_VOUT]  = |stat_q[0];
        sword[fas_pkg::SW_IOUT]  = |stat_q[1];
        sword[fas_pkg::SW_INPUT] = |stat_q[2];
        sword[fas_pkg::SW_PG_N]  = ~power_good;
    end

    // Snapshot: old values at the fault event, the rest at input loss
    assign snap_wr = running_q && vin_level < vin_off_th;

    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            for (int i = 0; i < 4; i++) begin
                old_q[i] <= 16'h0000;
            end
        end else if (raw_evt) begin
            old_q[0] <= vin_level;
            old_q[1] <= tele_vout;
            old_q[2] <= tele_iout;
            old_q[3] <= tele_duty;
        end
    end

    always_comb begin
        for (int i = 0; i < 4; i++) begin
            rec[fas_pkg::RW_OLD + i] = old_q[i];
        end
        for (int i = 0; i < NC; i++) begin
            rec[fas_pkg::RW_STAT + i] = {8'h00, stat_q[i]};
        end
        rec[fas_pkg::RW_VIN]    = vin_level;
        rec[fas_pkg::RW_VOUT]   = tele_vout;
        rec[fas_pkg::RW_IOUT]   = tele_iout;
        rec[fas_pkg::RW_TEMP1]  = tele_temp1;
        rec[fas_pkg::RW_TEMP2]  = tele_temp2;
        rec[fas_pkg::RW_TIME]   = op_time;
        rec[fas_pkg::RW_SWORD]  = sword;
        rec[fas_pkg::RW_SBYTE]  = {8'h00, sbyte};
        rec[fas_pkg::RW_CYCLES] = cycles_q + 16'h0001;
    end

    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            wr_ptr_q <= '0;
            cycles_q <= 16'h0000;
            for (int d = 0; d < CAP_DEPTH; d++) begin
                for (int w = 0; w < fas_pkg::REC_WORDS; w++) begin
                    mem_q[d][w] <= 16'h0000;
                end
            end
        end else if (snap_wr) begin
            mem_q[wr_ptr_q] <= rec;
            wr_ptr_q        <= wr_ptr_q + 1'b1;
            cycles_q        <= cycles_q + 16'h0001;
        end
    end

    // Newest record is selection zero
    assign rd_slot = wr_ptr_q - sel_q - 1'b1;

    // Read answers, low byte first
    always_comb begin
        logic [15:0] w;
        w = 16'h0000;
        if (cmd_q == fas_pkg::CMD_CAP_READ && tx_idx < 8'(2 * fas_pkg::REC_WORDS)) begin
            w = mem_q[rd_slot][5'(tx_idx >> 1)];
        end else if (cmd_q == fas_pkg::CMD_STAT_BYTE) begin
            w = {8'h00, sbyte};
        end else if (cmd_q == fas_pkg::CMD_STAT_WORD) begin
            w = sword;
        end else if (cmd_q >= fas_pkg::CMD_STAT_FIRST &&
                     cmd_q < fas_pkg::CMD_STAT_FIRST + 8'(NC)) begin
            w = {8'h00, stat_q[3'(cmd_q - fas_pkg::CMD_STAT_FIRST)]};
        end else if (cmd_q == fas_pkg::CMD_VOUT_SET) begin
            w = vout_q;
        end else if (cmd_q == fas_pkg::CMD_VOUT_TRIM) begin
            w = trim_q;
        end else if (cmd_q == fas_pkg::CMD_CAP_SELECT) begin
            w = 16'(sel_q);
        end
        tx_data = tx_idx[0] ? w[15:8] : w[7:0];
    end

    sequence s_cleared;
        (clr || en_rise) && !evt_any ##1 !alert_q;
    endsequence
    property p_alert_set;
        @(posedge clk) disable iff (reset) evt_any |=> alert_q ##1 alert_line_oe;
    endproperty
    a_alert_set: assert property (p_alert_set) else $error("alert not raised");
    property p_alert_hold;
        @(posedge clk) disable iff (reset)
            alert_q && !clr && !en_rise |=> alert_q;
    endproperty
    a_alert_hold: assert property (p_alert_hold) else $error("alert dropped");
    property p_alert_clear;
        @(posedge clk) disable iff (reset) alert_q && (clr || en_rise) && !evt_any |-> s_cleared;
    endproperty
    a_alert_clear: assert property (p_alert_clear) else $error("alert kept");
    property p_mask;
        @(posedge clk) disable iff (reset)
            $rose(alert_q) |-> $past((fault_vout & ~mask_q[0]) != 8'h00 ||
                                     (fault_iout & ~mask_q[1]) != 8'h00 ||
                                     (fault_input & ~mask_q[2]) != 8'h00 ||
                                     (fault_temp & ~mask_q[3]) != 8'h00 ||
                                     (fault_cml & ~mask_q[4]) != 8'h00);
    endproperty
    a_mask: assert property (p_mask) else $error("masked alert");
    property p_latch;
        @(posedge clk) disable iff (reset)
            !clr |=> (stat_q[0] & $past(stat_q[0])) == $past(stat_q[0]);
    endproperty
    a_latch: assert property (p_latch) else $error("status lost");
    property p_snap;
        @(posedge clk) disable iff (reset)
            snap_wr |=> cycles_q == $past(cycles_q) + 16'h0001 && !running_q;
    endproperty
    a_snap: assert property (p_snap) else $error("snapshot not stored");
    property p_old;
        @(posedge clk) disable iff (reset) raw_evt |=> old_q[0] == $past(vin_level);
    endproperty
    a_old: assert property (p_old) else $error("old value not latched");
    property p_hyst;
        @(posedge clk) disable iff (reset)
            running_q && vin_level >= vin_off_th |=> running_q;
    endproperty
    a_hyst: assert property (p_hyst) else $error("turned off above threshold");
    property p_rc;
        @(posedge clk) disable iff (reset)
            $changed(rc_open_q) |-> $past(rc_cnt_q) == 13'(RC_HOLD_CYC - 1);
    endproperty
    a_rc: assert property (p_rc) else $error("pin accepted too early");
    property p_neg;
        @(posedge clk) disable iff (reset) rc_open_q |=> !output_enable;
    endproperty
    a_neg: assert property (p_neg) else $error("on while pin open");
    property p_store;
        @(posedge clk) disable iff (reset) store && !boot_q |=> uvout_q == $past(vout_q);
    endproperty
    a_store: assert property (p_store) else $error("store failed");
    property p_restore;
        @(posedge clk) disable iff (reset)
            restore && !boot_q |=> vout_q == fas_pkg::DEF_VOUT;
    endproperty
    a_restore: assert property (p_restore) else $error("restore failed");
endmodule

// [fas_pkg.sv]
// Constants shared by the fault, alert, snapshot and link logic
package fas_pkg;
    // Command codes
    localparam logic [7:0] CMD_CLEAR_FAULTS = 8'h03;
    localparam logic [7:0] CMD_RESTORE_DEF  = 8'h12;
    localparam logic [7:0] CMD_STORE_USER   = 8'h15;
    localparam logic [7:0] CMD_ALERT_MASK   = 8'h1b;
    localparam logic [7:0] CMD_VOUT_SET     = 8'h21;
    localparam logic [7:0] CMD_VOUT_TRIM    = 8'h22;
    localparam logic [7:0] CMD_STAT_BYTE    = 8'h78;
    localparam logic [7:0] CMD_STAT_WORD    = 8'h79;
    localparam logic [7:0] CMD_STAT_FIRST   = 8'h7a;
    localparam logic [7:0] CMD_CAP_SELECT   = 8'hd5;
    localparam logic [7:0] CMD_CAP_READ     = 8'hd7;
    // Status classes: vout, iout, input, temperature, communication
    localparam int N_CLASS = 5;
    // Status byte and word summary bit positions
    localparam int SB_OFF    = 6;
    localparam int SB_CML    = 1;
    localparam int SB_OTHER  = 0;
    localparam int SW_VOUT   = 15;
    localparam int SW_IOUT   = 14;
    localparam int SW_INPUT  = 13;
    localparam int SW_PG_N   = 11;
    // Factory defaults of the active settings
    localparam logic [15:0] DEF_VOUT = 16'h6400;
    localparam logic [15:0] DEF_TRIM = 16'h0000;
    localparam logic [7:0]  DEF_MASK = 8'h00;
    // Snapshot record layout in 16-bit words
    localparam int REC_WORDS = 18;
    localparam int RW_OLD    = 0;
    localparam int RW_VIN    = 4;
    localparam int RW_VOUT   = 5;
    localparam int RW_IOUT   = 6;
    localparam int RW_TEMP1  = 7;
    localparam int RW_TEMP2  = 8;
    localparam int RW_TIME   = 9;
    localparam int RW_SWORD  = 10;
    localparam int RW_SBYTE  = 11;
    localparam int RW_STAT   = 12;
    localparam int RW_CYCLES = 17;
    localparam int CAP_DEPTH = 4;
    // Remote on/off hold time
    localparam int CLK_PERIOD_NS = 25;
    localparam int RC_HOLD_NS    = 150000;
    localparam int RC_HOLD_CYC   = (RC_HOLD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    // Link address (arbitrary)
    localparam logic [6:0] LINK_ADDR = 7'h10;
endpackage

// [fas_link.sv]
// Two-wire bus slave: byte receive, byte transmit, acknowledge
module fas_link #(
    parameter logic [6:0] ADDR = fas_pkg::LINK_ADDR
) (
    // Clock and reset
    input  wire logic       clk,
    input  wire logic       reset,
    // Bus pins
    input  wire logic       scl_in,
    input  wire logic       sda_in,
    output logic            sda_out,
    output logic            sda_oe,
    // Byte side
    output logic            rx_valid,
    output logic [7:0]      rx_data,
    output logic [7:0]      rx_idx,
    output logic [7:0]      tx_idx,
    input  wire logic [7:0] tx_data
);
    typedef enum logic [1:0] {
        FAS_IDLE = 2'b00,
        FAS_ADDR = 2'b01,
        FAS_WR   = 2'b11,
        FAS_RD   = 2'b10
    } fas_link_t;

    fas_link_t   st_q;
    logic [1:0]  scl_sy;
    logic [1:0]  sda_sy;
    logic        scl_d;
    logic        sda_d;
    logic [3:0]  bit_q;
    logic [7:0]  sh_q;
    logic [7:0]  txsh_q;
    logic [7:0]  cnt_q;
    logic        nack_q;
    logic        rise;
    logic        fall;
    logic        start;
    logic        stop;

    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            scl_sy <= 2'h3;
            sda_sy <= 2'h3;
            scl_d  <= 1'b1;
            sda_d  <= 1'b1;
        end else begin
            scl_sy <= {scl_sy[0], scl_in};
            sda_sy <= {sda_sy[0], sda_in};
            scl_d  <= scl_sy[1];
            sda_d  <= sda_sy[1];
        end
    end

    assign rise  = scl_sy[1] & ~scl_d;
    assign fall  = ~scl_sy[1] & scl_d;
    assign start = scl_sy[1] & scl_d & sda_d & ~sda_sy[1];
    assign stop  = scl_sy[1] & scl_d & ~sda_d & sda_sy[1];

    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            st_q     <= FAS_IDLE;
            bit_q    <= 4'h0;
            sh_q     <= 8'h00;
            txsh_q   <= 8'h00;
            cnt_q    <= 8'h00;
            nack_q   <= 1'b0;
            sda_out  <= 1'b0;
            sda_oe   <= 1'b0;
            rx_valid <= 1'b0;
            rx_data  <= 8'h00;
            rx_idx   <= 8'h00;
            tx_idx   <= 8'h00;
        end else begin
            rx_valid <= 1'b0;
            if (start) begin
                st_q   <= FAS_ADDR;
                bit_q  <= 4'h0;
                cnt_q  <= 8'h00;
                sda_oe <= 1'b0;
            end else if (stop) begin
                st_q   <= FAS_IDLE;
                sda_oe <= 1'b0;
            end else if (st_q != FAS_IDLE) begin
                if (rise && bit_q < 4'h8) begin
                    sh_q  <= {sh_q[6:0], sda_sy[1]};
                    bit_q <= bit_q + 4'h1;
                end else if (rise && bit_q == 4'h9) begin
                    nack_q <= sda_sy[1];
                end else if (fall && bit_q == 4'h8) begin
                    bit_q <= 4'h9;
                    unique case (st_q)
                        FAS_ADDR: begin
                            if (sh_q[7:1] == ADDR) begin
                                sda_oe <= 1'b1;
                                tx_idx <= 8'h00;
                                st_q   <= sh_q[0] ? FAS_RD : FAS_WR;
                            end else begin
                                st_q <= FAS_IDLE;
                            end
                        end
                        FAS_WR: begin
                            sda_oe   <= 1'b1;
                            rx_valid <= 1'b1;
                            rx_data  <= sh_q;
                            rx_idx   <= cnt_q;
                            cnt_q    <= cnt_q + 8'h01;
                        end
                        default: begin
                            sda_oe <= 1'b0;
                        end
                    endcase
                end else if (fall && bit_q == 4'h9) begin
                    bit_q <= 4'h0;
                    if (st_q == FAS_RD && !nack_q) begin
                        sda_oe <= ~tx_data[7];
                        txsh_q <= {tx_data[6:0], 1'b0};
                        tx_idx <= tx_idx + 8'h01;
                    end else begin
                        sda_oe <= 1'b0;
                        if (st_q == FAS_RD) begin
                            st_q <= FAS_IDLE;
                        end
                    end
                end else if (fall && st_q == FAS_RD && bit_q != 4'h0) begin
                    sda_oe <= ~txsh_q[7];
                    txsh_q <= {txsh_q[6:0], 1'b0};
                end
            end
        end
    end
endmodule

// [fas_host.sv]
// Bus host model: open-drain master on the two-wire link
module fas_host (
    // Wired data level
    input wire logic sda_w,
    // Host-driven lines, 1 means released
    output logic     scl,
    output logic     sda
);
    timeunit 1ns;
    timeprecision 100ps;
    logic [7:0] rb [0:35];
    logic [7:0] nu;
    logic       ak;
    initial begin
        scl = 1'b1;
        sda = 1'b1;
    end
    // Data set while the clock is low, sampled while it is high
    task automatic xfer(input logic b, output logic r);
        sda = b;
        #50 scl = 1'b1;
        #50 r = sda_w;
        #50 scl = 1'b0;
        #50;
    endtask
    task automatic byte_io(input logic [7:0] w, input logic l, output logic [7:0] r,
                           output logic a);
        for (int i = 7; i >= 0; i--) xfer(w[i], r[i]);
        xfer(l, a);
    endtask
    // Start when a is 1, stop when a is 0
    task automatic cond(input logic a);
        sda = a;
        #50 scl = 1'b1;
        #50 sda = ~a;
        #50 scl = ~a;
        #50;
    endtask
    task automatic xact(input logic [7:0] c, input int n, input logic [15:0] d, input bit is_rd);
        cond(1'b1);
        byte_io({fas_pkg::LINK_ADDR, 1'b0}, 1'b1, nu, ak);
        byte_io(c, 1'b1, nu, ak);
        for (int i = 0; i < n && !is_rd; i++) byte_io(d[8*i+:8], 1'b1, nu, ak);
        if (is_rd) cond(1'b1);
        if (is_rd) byte_io({fas_pkg::LINK_ADDR, 1'b1}, 1'b1, nu, ak);
        for (int i = 0; i < n && is_rd; i++) byte_io(8'hff, i == n - 1, rb[i], ak);
        cond(1'b0);
    endtask
endmodule

// [testbench.sv]
// Self-checking bench for the fault, alert and snapshot block
module testbench;
    timeunit 1ns;
    timeprecision 100ps;
    localparam int HOLD = 20;
    logic        clk = 1'b0;
    logic        reset = 1'b1;
    logic        pin = 1'b1;
    logic        pg = 1'b1;
    logic [15:0] vin = 16'h0000;
    logic [15:0] th [2] = '{16'h0100, 16'h00c0};
    logic [7:0]  fc [5] = '{default: 8'h00};
    logic [15:0] tv [6] = '{16'h1111, 16'h2222, 16'h3333, 16'h4444, 16'h5555, 16'h6666};
    logic        scl, hsda, sda_oe, sda_out, al_oe, al_out, oen;
    logic [15:0] vt;
    int          n_fail = 0;
    int          cmp_count = 0;
    wire logic   sda_w = hsda & (sda_out | ~sda_oe);
    fas_host h (.sda_w(sda_w), .scl(scl), .sda(hsda));
    fas_fault_snapshot #(.RC_HOLD_CYC(HOLD), .CAP_DEPTH(4)) DUT (
        .clk(clk), .reset(reset), .scl_in(scl), .sda_in(sda_w), .sda_out(sda_out),
        .sda_oe(sda_oe), .alert_line_out(al_out), .alert_line_oe(al_oe),
        .remote_onoff_pin(pin), .vin_level(vin), .vin_on_th(th[0]), .vin_off_th(th[1]),
        .fault_vout(fc[0]), .fault_iout(fc[1]), .fault_input(fc[2]), .fault_temp(fc[3]),
        .fault_cml(fc[4]), .power_good(pg), .tele_vout(tv[0]), .tele_iout(tv[1]),
        .tele_duty(tv[2]), .tele_temp1(tv[3]), .tele_temp2(tv[4]), .op_time(tv[5]),
        .output_enable(oen), .vout_target(vt));
    initial begin
        forever #12.5 clk = ~clk;
    end
    task automatic check(input string nm, input logic [15:0] got, input logic [15:0] exp);
        cmp_count++;
        if (got !== exp) begin
            n_fail++;
            $display("unexpected %s expected %h seen %h", nm, exp, got);
        end
    endtask
    task automatic complete_run;
        $display("comparisons %0d mismatches %0d", cmp_count, n_fail);
        if (n_fail == 0 && cmp_count > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask
    task automatic wait_clk(input int n);
        repeat (n) @(negedge clk);
    endtask
    initial begin
        #1ms;
        n_fail++;
        complete_run();
    end
    initial begin
        wait_clk(2);
        reset = 1'b0;
        check("vout", vt, 16'h6400);
        vin = 16'h0120;
        pin = 1'b0;
        wait_clk(HOLD);
        check("early on", oen, 1'b0);
        wait_clk(8);
        check("on", oen, 1'b1);
        for (int c = 0; c < 5; c++) begin
            fc[c] = 8'h01;
            wait_clk(4);
            check("alert set", al_oe, 1'b1);
            check("alert level", al_out, 1'b0);
            fc[c] = 8'h00;
            wait_clk(4);
            check("alert held", al_oe, 1'b1);
            if (c == 0) begin
                h.xact(fas_pkg::CMD_STAT_WORD, 2, 16'h0000, 1'b1);
                check("word", {h.rb[1], h.rb[0]}, 16'h8000);
            end
            h.xact(fas_pkg::CMD_CLEAR_FAULTS, 0, 16'h0000, 1'b0);
            check("alert clear", al_oe, 1'b0);
        end
        h.xact(fas_pkg::CMD_ALERT_MASK, 2, 16'h017a, 1'b0);
        fc[0] = 8'h01;
        wait_clk(4);
        check("masked", al_oe, 1'b0);
        fc[0] = 8'h00;
        h.xact(fas_pkg::CMD_STAT_FIRST, 1, 16'h0000, 1'b1);
        check("vout status", h.rb[0], 8'h01);
        h.xact(fas_pkg::CMD_VOUT_SET, 2, 16'h1234, 1'b0);
        check("set", vt, 16'h1234);
        h.xact(fas_pkg::CMD_VOUT_TRIM, 2, 16'h0010, 1'b0);
        check("trim", vt, 16'h1244);
        h.xact(fas_pkg::CMD_STORE_USER, 0, 16'h0000, 1'b0);
        // Settle time after a store, scaled down to keep the run short
        wait_clk(200);
        check("stored", vt, 16'h1244);
        h.xact(fas_pkg::CMD_RESTORE_DEF, 0, 16'h0000, 1'b0);
        check("restore", vt, 16'h6400);
        vin = 16'h00d0;
        wait_clk(4);
        check("hyst", oen, 1'b1);
        vin = 16'h00b0;
        wait_clk(4);
        check("off", oen, 1'b0);
        h.xact(fas_pkg::CMD_STAT_BYTE, 1, 16'h0000, 1'b1);
        check("byte", h.rb[0], 8'h40);
        vin = 16'h0120;
        h.xact(fas_pkg::CMD_CAP_READ, 36, 16'h0000, 1'b1);
        check("old vin", {h.rb[1], h.rb[0]}, 16'h0120);
        check("vin", {h.rb[9], h.rb[8]}, 16'h00b0);
        check("temp2", {h.rb[17], h.rb[16]}, tv[4]);
        check("cycles", {h.rb[35], h.rb[34]}, 16'h0001);
        fc[1] = 8'h02;
        wait_clk(4);
        fc[1] = 8'h00;
        check("alert again", al_oe, 1'b1);
        vin = 16'h00a0;
        wait_clk(4);
        vin = 16'h0120;
        h.xact(fas_pkg::CMD_CAP_SELECT, 1, 16'h0001, 1'b0);
        h.xact(fas_pkg::CMD_CAP_READ, 10, 16'h0000, 1'b1);
        check("prev vin", {h.rb[9], h.rb[8]}, 16'h00b0);
        check("re-enable", al_oe, 1'b0);
        pin = 1'b1;
        wait_clk(HOLD + 4);
        check("pin open", oen, 1'b0);
        complete_run();
    end
endmodule
